// File: design/acimr_defs.svh
// Register offsets, field positions and reset values of the ADC mode slice
`ifndef ACIMR_DEFS_SVH
`define ACIMR_DEFS_SVH
// Register byte offsets
`define ACIMR_OFF_IMC 12'h000
`define ACIMR_OFF_RDY_LO 12'h004
`define ACIMR_OFF_RDY_HI 12'h008
`define ACIMR_OFF_IST 12'h00C
`define ACIMR_OFF_IMSK 12'h010
// Mode field: differential bit of input 3, stride 2 per input
`define ACIMR_DIFF_LSB 7
`define ACIMR_SIGN_LSB 6
`define ACIMR_MODE_INPUTS 8
// Writable bits of the mode register (bits 21..6)
`define ACIMR_IMC_MASK 32'h003F_FFC0
`define ACIMR_IMC_RST 32'h0000_0000
// Implemented ready flags, full package
`define ACIMR_RDY_LO_FULL 32'h0FFF_FFFF
`define ACIMR_RDY_HI_FULL 32'h003F_E3FE
// Flags missing on the smallest package
`define ACIMR_RDY_LO_SMALL 32'h00F0_0000
`define ACIMR_RDY_HI_SMALL 32'h0000_E3FE
`define ACIMR_RDY_RST 32'h0000_0000
// Interrupt status and mask layout
`define ACIMR_IRQ_W 3
`define ACIMR_IRQ_LO 0
`define ACIMR_IRQ_HI 1
`define ACIMR_IRQ_OVR 2
`define ACIMR_IRQ_RST 3'h0
`endif

// File: design/acimr_pkg.sv
// Types shared by the ADC mode and ready status slice
package acimr_pkg;
  // All state of the slice
  typedef struct packed {
    logic [31:0] imc;
    logic [31:0] rdy_lo;
    logic [31:0] rdy_hi;
    logic [2:0] ist;
    logic [2:0] imsk;
    logic [31:0] prdata;
    logic pslverr;
  } acimr_state_s;
endpackage

// File: design/acimr_top.sv
// APB register slice: ADC input modes and conversion ready flags
`timescale 1ns/1ps
`default_nettype none
`include "acimr_defs.svh"

// Overview of operation
// R01 - Mode bit 21 set: input 10 differential against input 1.
// R02 - Mode bit 19 set: input 9 differential against input 1.
// R03 - Mode bit 17 set: input 8 differential against input 1.
// R04 - Mode bit 15 set: input 7 differential against input 1.
// R05 - Mode bit 13 set: input 6 differential against input 1.
// R06 - Mode bit 11 set: input 5 differential against input 11.
// R07 - Mode bit 9 set: input 4 differential against input 10.
// R08 - Mode bit 7 set: input 3 differential against input 27.
// R09 - Even bits 20 down to 6 select signed results, inputs 10 to 3.
// R10 - Low ready register holds one flag per input 0..27 at its number.
// R11 - A flag sets when its result lands in the result register.
// R12 - A flag clears when software reads that result register.
// R13 - Low ready register bits 31..28 always read zero.
// R14 - Small package build removes absent flags; they read zero.
// R15 - High ready flags for inputs 33..41 and 45..53 behave the same way.
// R16 - Software writes never change any ready flag.
// R17 - A set in the same cycle as the read wins.
module acimr_top #(
  parameter bit FULL_PACKAGE = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] result_load_low,
  input wire logic [31:0] result_load_high,
  input wire logic [31:0] result_read_low,
  input wire logic [31:0] result_read_high,
  output logic [7:0] differential_select,
  output logic [7:0] signed_result,
  output logic [31:0] ready_flags_low,
  output logic [31:0] ready_flags_high,
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration checks and flag masks
  // ----------------------------------------------------------------
  // Small build may only remove positions the full build implements
  if ((`ACIMR_RDY_LO_SMALL & ~`ACIMR_RDY_LO_FULL) != 32'h0000_0000 ||
      (`ACIMR_RDY_HI_SMALL & ~`ACIMR_RDY_HI_FULL) != 32'h0000_0000
      ) begin : g_bad_masks
    $error("Small package mask outside implemented flags");
  end

  // Implemented flag positions for this build
  localparam logic [31:0] LO_MASK = FULL_PACKAGE ?
    `ACIMR_RDY_LO_FULL : (`ACIMR_RDY_LO_FULL & ~`ACIMR_RDY_LO_SMALL); // R14
  localparam logic [31:0] HI_MASK = FULL_PACKAGE ?
    `ACIMR_RDY_HI_FULL : (`ACIMR_RDY_HI_FULL & ~`ACIMR_RDY_HI_SMALL); // R14

  acimr_pkg::acimr_state_s st_reg;
  acimr_pkg::acimr_state_s st_next;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic hit_imc;
  logic hit_lo;
  logic hit_hi;
  logic hit_ist;
  logic hit_imsk;
  logic hit_any;
  logic [31:0] byte_mask;

  // Phase and address decode
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc = access_ph & pwrite;
  assign hit_imc = (paddr == `ACIMR_OFF_IMC);
  assign hit_lo = (paddr == `ACIMR_OFF_RDY_LO);
  assign hit_hi = (paddr == `ACIMR_OFF_RDY_HI);
  assign hit_ist = (paddr == `ACIMR_OFF_IST);
  assign hit_imsk = (paddr == `ACIMR_OFF_IMSK);
  assign hit_any = hit_imc | hit_lo | hit_hi | hit_ist | hit_imsk;
  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                      {8{pstrb[1]}}, {8{pstrb[0]}}};

  // ----------------------------------------------------------------
  // Flag events
  // ----------------------------------------------------------------
  logic [31:0] ld_lo;
  logic [31:0] ld_hi;
  logic [31:0] rd_lo;
  logic [31:0] rd_hi;
  logic [2:0] irq_ev;

  // Only implemented positions see events
  assign ld_lo = result_load_low & LO_MASK; // R10
  assign ld_hi = result_load_high & HI_MASK; // R15
  assign rd_lo = result_read_low & LO_MASK;
  assign rd_hi = result_read_high & HI_MASK;

  // New result per group, and overrun of an unread result
  assign irq_ev[`ACIMR_IRQ_LO] = |ld_lo;
  assign irq_ev[`ACIMR_IRQ_HI] = |ld_hi;
  assign irq_ev[`ACIMR_IRQ_OVR] = |(ld_lo & st_reg.rdy_lo & ~rd_lo) |
                                  |(ld_hi & st_reg.rdy_hi & ~rd_hi);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // Mode register write, byte lanes honoured
    if (wr_acc && hit_imc) begin
      st_next.imc = ((st_reg.imc & ~byte_mask) | (pwdata & byte_mask))
                    & `ACIMR_IMC_MASK;
    end
    // Interrupt mask write
    if (wr_acc && hit_imsk && pstrb[0]) begin
      st_next.imsk = pwdata[`ACIMR_IRQ_W-1:0];
    end
    // Ready flags: read clears, load sets, set wins; bus writes ignored
    // Clear from result read strobes only
    st_next.rdy_lo = st_reg.rdy_lo & ~rd_lo; // R12 R16
    st_next.rdy_hi = st_reg.rdy_hi & ~rd_hi; // R15 R16
    // Set applied after the clear so a same-cycle load wins
    st_next.rdy_lo = (st_next.rdy_lo | ld_lo) & LO_MASK; // R11 R17
    st_next.rdy_hi = (st_next.rdy_hi | ld_hi) & HI_MASK; // R15 R17
    // Sticky status, cleared by read, event wins over clear.
    // Only bits returned in the captured read data are cleared, so an
    // event landing between setup and access survives to the next read.
    if (access_ph && !pwrite && hit_ist) begin
      st_next.ist = (st_reg.ist & ~st_reg.prdata[`ACIMR_IRQ_W-1:0]) | irq_ev;
    end else begin
      st_next.ist = st_reg.ist | irq_ev;
    end
    // Read data captured in setup so it stands through access
    st_next.pslverr = setup_ph & ~hit_any;
    if (setup_ph) begin
      st_next.prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (1'b1)
          hit_imc: st_next.prdata = st_reg.imc;
          hit_lo: st_next.prdata = st_reg.rdy_lo & LO_MASK; // R10 R13
          hit_hi: st_next.prdata = st_reg.rdy_hi & HI_MASK; // R15
          hit_ist: st_next.prdata = {29'h0, st_reg.ist};
          hit_imsk: st_next.prdata = {29'h0, st_reg.imsk};
          default: st_next.prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg.imc <= `ACIMR_IMC_RST;
      st_reg.rdy_lo <= `ACIMR_RDY_RST;
      st_reg.rdy_hi <= `ACIMR_RDY_RST;
      st_reg.ist <= `ACIMR_IRQ_RST;
      st_reg.imsk <= `ACIMR_IRQ_RST;
      st_reg.prdata <= 32'h0000_0000;
      st_reg.pslverr <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait state slave
  assign pready = 1'b1;
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr & access_ph;

  // Differential selects, index 0 is input 3
  assign differential_select[7] = st_reg.imc[21]; // R01
  assign differential_select[6] = st_reg.imc[19]; // R02
  assign differential_select[5] = st_reg.imc[17]; // R03
  assign differential_select[4] = st_reg.imc[15]; // R04
  assign differential_select[3] = st_reg.imc[13]; // R05
  assign differential_select[2] = st_reg.imc[11]; // R06
  assign differential_select[1] = st_reg.imc[9]; // R07
  assign differential_select[0] = st_reg.imc[7]; // R08

  // Signed format bits sit just below each differential bit
  genvar gi;
  for (gi = 0; gi < `ACIMR_MODE_INPUTS; gi++) begin : g_sign
    assign signed_result[gi] = st_reg.imc[`ACIMR_SIGN_LSB + 2*gi]; // R09
  end

  assign ready_flags_low = st_reg.rdy_lo;
  assign ready_flags_high = st_reg.rdy_hi;
  assign irq = |(st_reg.ist & st_reg.imsk);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Mode register: every select follows its written bit
  AST_INPUT10_DIFFERENTIAL_SELECT: assert property ( // R01
    differential_select[7] == st_reg.imc[21] and
    (wr_acc && hit_imc && pstrb[2] |=> differential_select[7] ==
     $past(pwdata[21])))
    else $error("input 10 differential select wrong");

  AST_INPUT3_DIFFERENTIAL_SELECT: assert property ( // R08
    wr_acc && hit_imc && pstrb[0] |=>
    differential_select[0] == $past(pwdata[7]))
    else $error("input 3 differential select wrong");

  AST_INPUT9_DIFFERENTIAL_SELECT: assert property ( // R02
    wr_acc && hit_imc && pstrb[2] |=>
    differential_select[6] == $past(pwdata[19]))
    else $error("input 9 differential select wrong");

  AST_INPUT8_DIFFERENTIAL_SELECT: assert property ( // R03
    wr_acc && hit_imc && pstrb[2] |=>
    differential_select[5] == $past(pwdata[17]))
    else $error("input 8 differential select wrong");

  AST_INPUT7_DIFFERENTIAL_SELECT: assert property ( // R04
    wr_acc && hit_imc && pstrb[1] |=>
    differential_select[4] == $past(pwdata[15]))
    else $error("input 7 differential select wrong");

  AST_INPUT6_DIFFERENTIAL_SELECT: assert property ( // R05
    wr_acc && hit_imc && pstrb[1] |=>
    differential_select[3] == $past(pwdata[13]))
    else $error("input 6 differential select wrong");

  AST_INPUT5_DIFFERENTIAL_SELECT: assert property ( // R06
    wr_acc && hit_imc && pstrb[1] |=>
    differential_select[2] == $past(pwdata[11]))
    else $error("input 5 differential select wrong");

  AST_INPUT4_DIFFERENTIAL_SELECT: assert property ( // R07
    wr_acc && hit_imc && pstrb[1] |=>
    differential_select[1] == $past(pwdata[9]))
    else $error("input 4 differential select wrong");

  AST_DIFF_MAP: assert property ( // R02
    differential_select[6:1] == {st_reg.imc[19], st_reg.imc[17],
      st_reg.imc[15], st_reg.imc[13], st_reg.imc[11], st_reg.imc[9]})
    else $error("differential select map wrong");

  AST_SIGN: assert property ( // R09
    wr_acc && hit_imc && (&pstrb) |=>
    signed_result == {$past(pwdata[20]), $past(pwdata[18]),
      $past(pwdata[16]), $past(pwdata[14]), $past(pwdata[12]),
      $past(pwdata[10]), $past(pwdata[8]), $past(pwdata[6])})
    else $error("signed result select wrong");

  AST_INPUT3_SIGNED_RESULT: assert property ( // R09
    wr_acc && hit_imc && pstrb[0] |=>
    signed_result[0] == $past(pwdata[6]))
    else $error("input 3 signed result select wrong");

  AST_MODE_BITS: assert property (
    (st_reg.imc & ~`ACIMR_IMC_MASK) == 32'h0000_0000)
    else $error("mode register holds bits outside 21 to 6");

  // Ready flags: set by results, cleared by reads, deaf to bus writes
  AST_FLAG_SET: assert property ( // R11
    result_load_low[5] |=> ready_flags_low[5])
    else $error("ready flag 5 not set by result");

  AST_FLAG_CLR: assert property ( // R12
    result_read_low[5] && !result_load_low[5] |=> !ready_flags_low[5])
    else $error("ready flag 5 not cleared by read");

  AST_LOAD_ALL: assert property ( // R11
    (result_load_low & LO_MASK) != 32'h0000_0000 |=>
    (ready_flags_low & $past(result_load_low & LO_MASK)) ==
    $past(result_load_low & LO_MASK))
    else $error("low ready flags not set by results");

  AST_READ_ALL: assert property ( // R12
    (result_read_low & ~result_load_low) != 32'h0000_0000 |=>
    (ready_flags_low & $past(result_read_low & ~result_load_low)) ==
    32'h0000_0000)
    else $error("low ready flags not cleared by reads");

  AST_FLAG_HOLD: assert property ( // R16
    wr_acc && (hit_lo || hit_hi) && result_read_low == 32'h0000_0000 &&
    result_load_low == 32'h0000_0000 |=>
    ready_flags_low == $past(ready_flags_low))
    else $error("bus write changed ready flag");

  AST_HI_HOLD: assert property ( // R16
    wr_acc && (hit_lo || hit_hi) && result_read_high == 32'h0000_0000 &&
    result_load_high == 32'h0000_0000 |=>
    ready_flags_high == $past(ready_flags_high))
    else $error("bus write changed high ready flag");

  AST_SET_WINS: assert property ( // R17
    result_load_high[21] && result_read_high[21] |=>
    ready_flags_high[21] == HI_MASK[21])
    else $error("set lost against read");

  AST_TOP_ZERO: assert property ( // R13
    ready_flags_low[31:28] == 4'h0 and
    (access_ph && !pwrite && hit_lo |-> prdata[31:28] == 4'h0))
    else $error("unimplemented low flag bits not zero");

  AST_PKG: assert property ( // R14
    (ready_flags_low & ~LO_MASK) == 32'h0000_0000 &&
    (ready_flags_high & ~HI_MASK) == 32'h0000_0000)
    else $error("absent ready flag set");

  AST_HIGH: assert property ( // R15
    result_load_high[13] |=> ready_flags_high[13] == HI_MASK[13])
    else $error("high ready flag not set");

  AST_HI_CLR: assert property ( // R15
    result_read_high[13] && !result_load_high[13] |=>
    !ready_flags_high[13])
    else $error("high ready flag not cleared by read");

  AST_HI_READ: assert property ( // R15
    setup_ph && !pwrite && hit_hi |=> prdata == $past(ready_flags_high))
    else $error("high ready register read wrong");

  AST_LO_READ: assert property ( // R10
    setup_ph && !pwrite && hit_lo |=> prdata == $past(ready_flags_low))
    else $error("low ready register read wrong");

  // Interrupt status and bus error response
  AST_IRQ: assert property (
    result_load_low[1] && st_reg.imsk[`ACIMR_IRQ_LO] && !wr_acc ##1
    !wr_acc && !(access_ph && hit_ist) |-> irq [*2])
    else $error("masked-in event did not raise irq");

  AST_IST_SET: assert property (
    irq_ev != 3'h0 |=> (st_reg.ist & $past(irq_ev)) == $past(irq_ev))
    else $error("interrupt event not recorded");

  AST_IST_CLEAR: assert property (
    access_ph && !pwrite && hit_ist && irq_ev == 3'h0 |=>
    (st_reg.ist & $past(prdata[`ACIMR_IRQ_W-1:0])) == 3'h0)
    else $error("status read did not clear returned bits");

  AST_OVR: assert property (
    result_load_low[1] && ready_flags_low[1] && !result_read_low[1] |=>
    st_reg.ist[`ACIMR_IRQ_OVR])
    else $error("overrun of an unread result not flagged");

  AST_SLVERR: assert property (
    access_ph && !hit_any |-> pslverr)
    else $error("unmapped access without error response");

  AST_SLVERR_OK: assert property (
    hit_any || !access_ph |-> !pslverr)
    else $error("error response on a mapped register");

  // Main scenarios
  COV_DIFF: cover property (wr_acc && hit_imc ##1 differential_select[7]);
  COV_RACE: cover property (result_load_low[3] && result_read_low[3]);
  COV_CLEAR: cover property (ready_flags_low[2] ##1 !ready_flags_low[2]);
  COV_IRQ: cover property (irq ##[1:4] !irq);
  COV_OVR: cover property (st_reg.ist[`ACIMR_IRQ_OVR]);

endmodule
`default_nettype wire

// File: tb/acimr_core_model.sv
// Conversion core model: drives result land and result read strobes
`timescale 1ns/1ps
`default_nettype none
module acimr_core_model (
  input wire logic clk,
  output logic [31:0] result_load_low,
  output logic [31:0] result_load_high,
  output logic [31:0] result_read_low,
  output logic [31:0] result_read_high
);
  // Strobes idle low from time zero
  initial begin
    result_load_low = 32'h0000_0000;
    result_load_high = 32'h0000_0000;
    result_read_low = 32'h0000_0000;
    result_read_high = 32'h0000_0000;
  end

  // One-cycle strobes, changed only just after a rising edge
  task automatic pulse(input logic [31:0] ll, lh, rl, rh);
    @(posedge clk);
    result_load_low <= ll;
    result_load_high <= lh;
    result_read_low <= rl;
    result_read_high <= rh;
    @(posedge clk);
    result_load_low <= 32'h0000_0000;
    result_load_high <= 32'h0000_0000;
    result_read_low <= 32'h0000_0000;
    result_read_high <= 32'h0000_0000;
  endtask
endmodule
`default_nettype wire

// File: tb/test_acimr_top.sv
// Self-checking bench of the ADC mode and ready status slice
`timescale 1ns/1ps
`default_nettype none
module test_acimr_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rll, rlh, rrl, rrh, ready_flags_low, ready_flags_high;
  logic pready, pslverr, irq;
  logic [7:0] differential_select, signed_result;
  logic [31:0] rd;
  logic er;
  logic [31:0] small_lo, small_hi;
  int failures = 0;
  int n_compared = 0;

  acimr_top dut_u (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .result_load_low(rll), .result_load_high(rlh),
    .result_read_low(rrl), .result_read_high(rrh),
    .differential_select(differential_select),
    .signed_result(signed_result), .ready_flags_low(ready_flags_low),
    .ready_flags_high(ready_flags_high), .irq(irq));

  // Smallest package build on the same bus and strobes
  acimr_top #(.FULL_PACKAGE(1'b0)) dut_small_u (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(), .pready(), .pslverr(),
    .result_load_low(rll), .result_load_high(rlh),
    .result_read_low(rrl), .result_read_high(rrh),
    .differential_select(), .signed_result(),
    .ready_flags_low(small_lo), .ready_flags_high(small_hi), .irq());

  acimr_core_model core_u (.clk(clk), .result_load_low(rll),
    .result_load_high(rlh), .result_read_low(rrl),
    .result_read_high(rrh));

  // Clock and watchdog
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    close_out();
  end

  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // APB transfer: setup, then access until pready at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Request held until pready is seen high at a rising edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // Reset values and an unmapped address
  task automatic t_reset;
    apb(1'b0, 12'h000, 32'h0);
    check("mode", rd, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0);
    check("rdy_lo", rd, 32'h0000_0000);
    apb(1'b0, 12'h014, 32'h0);
    check("slverr", {31'h0, er}, 32'h1);
  endtask

  // Each input's differential and signed bit alone
  task automatic t_mode;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h000, 32'h1 << (7 + 2 * i));
      check("diff", differential_select, 32'h1 << i);
      check("diff_sign", signed_result, 32'h0);
      apb(1'b1, 12'h000, 32'h1 << (6 + 2 * i));
      check("sign", signed_result, 32'h1 << i);
      check("single", differential_select, 32'h0);
    end
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    apb(1'b0, 12'h000, 32'h0);
    check("mode_rb", rd, 32'h003F_FFC0);
  endtask

  // Flags set, survive writes, clear on read, set wins
  task automatic t_flags;
    core_u.pulse(32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0, 32'h0);
    #1;
    check("flg_lo", ready_flags_low, 32'h0FFF_FFFF);
    check("small_lo", small_lo, 32'h0F0F_FFFF);
    check("small_hi", small_hi, 32'h003F_0000);
    apb(1'b0, 12'h004, 32'h0);
    check("rdy_lo", rd, 32'h0FFF_FFFF);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check("rdy_hi", rd, 32'h003F_E3FE);
    apb(1'b1, 12'h004, 32'h0);
    check("flg_wr", ready_flags_low, 32'h0FFF_FFFF);
    core_u.pulse(32'h0, 32'h0, 32'h20, 32'h2000);
    #1;
    check("clr_lo", ready_flags_low, 32'h0FFF_FFDF);
    check("clr_hi", ready_flags_high, 32'h003F_C3FE);
    core_u.pulse(32'h20, 32'h0, 32'h20, 32'h0);
    #1;
    check("both", ready_flags_low, 32'h0FFF_FFFF);
  endtask

  // Interrupt raised, masked and cleared by status read
  task automatic t_irq;
    check("irq_off", {31'h0, irq}, 32'h0);
    apb(1'b1, 12'h010, 32'h3);
    check("irq_on", {31'h0, irq}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    check("ist", rd, 32'h3);
    check("irq_clr", {31'h0, irq}, 32'h0);
    core_u.pulse(32'h0, 32'h2000, 32'h0, 32'h0);
    #1;
    check("irq_hi", {31'h0, irq}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    check("ist_hi", rd, 32'h2);
    core_u.pulse(32'h2, 32'h0, 32'h0, 32'h0);
    #1;
    check("irq_ovr", {31'h0, irq}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    check("ist_ovr", rd, 32'h5);
    check("irq_end", {31'h0, irq}, 32'h0);
  endtask

  task automatic close_out;
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_mode();
    t_flags();
    t_irq();
    close_out();
  end
endmodule
`default_nettype wire
